// File: core/uhmpc_defines.svh
`ifndef UHMPC_DEFINES_SVH
`define UHMPC_DEFINES_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define UHMPC_OFF_MISC 8'h68
`define UHMPC_OFF_PMCAP 8'h80
`define UHMPC_OFF_PMCSR 8'h84
`define UHMPC_OFF_MSICAP 8'h8C
// ----------------------------------------
// Misc register fields and resets
// ----------------------------------------
`define UHMPC_MISC_BASIC 0
`define UHMPC_MISC_BND64 1
`define UHMPC_MISC_PREF 2
`define UHMPC_MISC_RSV3 3
`define UHMPC_MISC_USREN 4
`define UHMPC_MISC_USRLO 5
`define UHMPC_MISC_PFLO 8
`define UHMPC_MISC_RSV15 15
`define UHMPC_MISC_RESET 16'h9000
`define UHMPC_PFLEN_RESET 7'h10
// ----------------------------------------
// Power management capability constants
// ----------------------------------------
`define UHMPC_PM_CAP_ID 8'h01
`define UHMPC_PM_NEXT_RESET 8'h8C
`define UHMPC_PM_REV 3'h3
`define UHMPC_AUX_RESET 3'h7
`define UHMPC_PME_SUPPORT 5'h1F
`define UHMPC_MSI_CAP_ID 8'h05
// Capability loadable 11-bit layout: {pmeSup, d2, d1, aux, dsi}
`define UHMPC_CAPLD_RESET 11'h7FE
`define UHMPC_PMCSR_STATE 0
`define UHMPC_PMCSR_NSR 3
`define UHMPC_PMCSR_PMEEN 8
`define UHMPC_PMCSR_DSEL 9
`define UHMPC_PMCSR_PMEST 15
// ----------------------------------------
// Read request sizes in bytes
// ----------------------------------------
`define UHMPC_MRRS_64 10'h040
`define UHMPC_MRRS_128 10'h080
`endif

// File: core/uhmpc_pkg.sv
package uhmpc_pkg;
	typedef enum logic [1:0]
	{
		UHMPC_D0 = 2'b00,
		UHMPC_D1 = 2'b01,
		UHMPC_D2 = 2'b10,
		UHMPC_D3HOT = 2'b11
	} uhmpc_pstate_e;

	typedef struct packed
	{
		logic [15:0] misc;
		logic [7:0] nextPtr;
		logic [10:0] capLoad;
		logic noSoftReset;
		uhmpc_pstate_e pstate;
		logic pmeEnable;
		logic [3:0] dataSelect;
		logic pmeStatus;
		logic hotReset;
		logic [31:0] rdData;
		logic rdValid;
	} uhmpc_state_s;
endpackage

// File: core/uhmpc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "uhmpc_defines.svh"

// Overview of operation
// - Basic mode bit allows one active controller
// - Boundary bit limits read request to 64
// - Prefetch bit enables high-speed controller prefetch
// - User size bit selects 2-bit size field
// - Prefetch length field bits 14:8, reset 10h
// - Defaults loadable by SMBus or EEPROM
// - Power_cap_identifier 01h, next pointer 8Ch
// - PM revision field reads 011b
// - DSI reads 0, aux current resets 111b
// - D1 and D2 support read one
// - Wake support field reads 11111b
// - Power state field reports D0 to D3hot
// - D3 to D0 write gives internal hot reset
// - No-soft-reset bit gates that internal reset
// - Wake enable bit allows PME message
// - Wake status W1C, zero in high-speed function
// - Data select RW, scale and data zero
// - Bits 19, 22, 23 read zero
// - Msi_cap_identifier reads 05h
module uhmpc_regs
	import uhmpc_pkg::*;
#(
	parameter bit HIGH_SPEED_FUNC = 1'b1
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic cfgRead,
	input wire logic cfgWrite,
	input wire logic [7:0] cfgAddr,
	input wire logic [31:0] cfgWrData,
	input wire logic [3:0] cfgByteEn,
	output logic [31:0] cfgRdData,
	output logic cfgRdValid,
	input wire logic loadValid,
	input wire logic [7:0] loadAddr,
	input wire logic [31:0] loadData,
	input wire logic wakeEvent,
	output logic basicMode,
	output logic [9:0] maxReadRequestBytes,
	output logic prefetchEnable,
	output logic [6:0] prefetch_length_dwords,
	output logic [1:0] powerState,
	output logic pmeRequest,
	output logic hotResetPulse
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] be);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] offset);
		return addr == offset;
	endfunction

	// ----------------------------------------
	// Read request sizing
	// ----------------------------------------
	// Boundary bit outranks the user size; reserved user codes fall back to 128
	function automatic logic [9:0] readSizeBytes(input logic [15:0] misc);
		logic [9:0] size;
		size = `UHMPC_MRRS_128;
		if (misc[`UHMPC_MISC_BND64])
		begin
			size = `UHMPC_MRRS_64;
		end
		else if (misc[`UHMPC_MISC_USREN])
		begin
			// Only code 00 is defined; reserved codes keep the safe size
			unique case (misc[`UHMPC_MISC_USRLO +: 2])
				2'h0: size = `UHMPC_MRRS_128;
				default: size = `UHMPC_MRRS_128;
			endcase
		end
		return size;
	endfunction

	// ----------------------------------------
	// Power state transitions
	// ----------------------------------------
	function automatic logic hotResetDue(input uhmpc_pstate_e prev, input logic [1:0] newState,
		input logic noSoftReset);
		logic due;
		due = 1'b0;
		if (prev == UHMPC_D3HOT && newState == 2'h0)
		begin
			// The external fundamental_reset_pin_n is never touched here
			due = !noSoftReset;
		end
		return due;
	endfunction

	// ----------------------------------------
	// Wake status update
	// ----------------------------------------
	// Set after clear, so a new event is never lost to a clear
	function automatic logic wakeStatusNext(input logic held, input logic clear, input logic set);
		logic res;
		res = held;
		if (clear)
		begin
			res = 1'b0;
		end
		if (set)
		begin
			res = 1'b1;
		end
		return res;
	endfunction

	// ----------------------------------------
	// Capability word view
	// ----------------------------------------
	// Bits 19 and 20 stay zero; bits 31:21 and the next pointer are loadable
	function automatic logic [31:0] capView(input logic [10:0] capLoad, input logic [7:0] nextPtr);
		logic [31:0] res;
		res = 32'h0000_0000;
		res[7:0] = `UHMPC_PM_CAP_ID;
		res[15:8] = nextPtr;
		res[18:16] = `UHMPC_PM_REV;
		res[31:21] = capLoad;
		return res;
	endfunction

	uhmpc_state_s cur;
	uhmpc_state_s nxt;
	logic [31:0] miscWord;
	logic [31:0] capWord;
	logic [31:0] pmcsrWord;
	logic [31:0] mw;
	logic [31:0] pw;
	logic wrMiscHit;
	logic wrPmHit;
	logic wakeClear;
	logic wakeSet;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	assign wrMiscHit = cfgWrite && addrHit(cfgAddr, `UHMPC_OFF_MISC);
	assign wrPmHit = cfgWrite && addrHit(cfgAddr, `UHMPC_OFF_PMCSR);
	assign wakeClear = wrPmHit && cfgByteEn[1] && cfgWrData[`UHMPC_PMCSR_PMEST];
	// High-speed function has no wake status, so events are ignored there
	assign wakeSet = wakeEvent && !HIGH_SPEED_FUNC;

	// ----------------------------------------
	// Read views
	// ----------------------------------------
	always_comb
	begin
		miscWord = {16'h0000, cur.misc};
		miscWord[7] = 1'b0;
		capWord = capView(cur.capLoad, cur.nextPtr);
		pmcsrWord = 32'h0000_0000;
		pmcsrWord[1:0] = cur.pstate;
		pmcsrWord[`UHMPC_PMCSR_NSR] = cur.noSoftReset;
		pmcsrWord[`UHMPC_PMCSR_PMEEN] = cur.pmeEnable;
		pmcsrWord[12:9] = cur.dataSelect;
		pmcsrWord[`UHMPC_PMCSR_PMEST] = cur.pmeStatus;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt = cur;
		nxt.hotReset = 1'b0;
		nxt.rdValid = cfgRead;
		mw = mergeBytes({16'h0000, cur.misc}, cfgWrData, cfgByteEn);
		pw = mergeBytes(pmcsrWord, cfgWrData, cfgByteEn);
		if (cfgRead)
		begin
			unique case (cfgAddr)
				`UHMPC_OFF_MISC: nxt.rdData = miscWord;
				`UHMPC_OFF_PMCAP: nxt.rdData = capWord;
				`UHMPC_OFF_PMCSR: nxt.rdData = pmcsrWord;
				`UHMPC_OFF_MSICAP: nxt.rdData = {24'h000000, `UHMPC_MSI_CAP_ID};
				default: nxt.rdData = 32'h0000_0000;
			endcase
		end
		// Side-band default load; reset defaults replaced after reset
		if (loadValid)
		begin
			unique case (loadAddr)
				`UHMPC_OFF_MISC: nxt.misc = loadData[15:0];
				`UHMPC_OFF_PMCAP:
				begin
					nxt.nextPtr = loadData[15:8];
					nxt.capLoad = loadData[31:21];
				end
				`UHMPC_OFF_PMCSR: nxt.noSoftReset = loadData[`UHMPC_PMCSR_NSR];
				default: ;
			endcase
		end
		if (wrMiscHit)
		begin
			nxt.misc = mw[15:0];
		end
		if (wrPmHit)
		begin
			if (cfgByteEn[0])
			begin
				nxt.pstate = uhmpc_pstate_e'(pw[1:0]);
				// Hot reset without the fundamental_reset_pin_n
				if (hotResetDue(cur.pstate, pw[1:0], cur.noSoftReset))
				begin
					nxt.hotReset = 1'b1;
				end
			end
			nxt.pmeEnable = pw[`UHMPC_PMCSR_PMEEN];
			nxt.dataSelect = pw[12:9];
		end
		// Set wins over a clear in the same cycle
		nxt.pmeStatus = wakeStatusNext(cur.pmeStatus, wakeClear, wakeSet);
		if (cur.hotReset)
		begin
			// Internal reset restores power state, wake enable and data select, not misc, wake status or the loaded fields
			nxt.pstate = UHMPC_D0;
			nxt.pmeEnable = 1'b0;
			nxt.dataSelect = 4'h0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur.misc <= `UHMPC_MISC_RESET;
			cur.nextPtr <= `UHMPC_PM_NEXT_RESET;
			cur.capLoad <= `UHMPC_CAPLD_RESET;
			cur.noSoftReset <= 1'b1;
			cur.pstate <= UHMPC_D0;
			cur.pmeEnable <= 1'b0;
			cur.dataSelect <= 4'h0;
			cur.pmeStatus <= 1'b0;
			cur.hotReset <= 1'b0;
			cur.rdData <= 32'h0000_0000;
			cur.rdValid <= 1'b0;
		end
		else if (clkEn)
		begin
			cur <= nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cfgRdData = cur.rdData;
	assign cfgRdValid = cur.rdValid;
	assign basicMode = cur.misc[`UHMPC_MISC_BASIC];
	assign prefetchEnable = cur.misc[`UHMPC_MISC_PREF];
	assign prefetch_length_dwords = cur.misc[14:8];
	assign powerState = cur.pstate;
	assign pmeRequest = cur.pmeEnable & cur.pmeStatus;
	assign hotResetPulse = cur.hotReset;

	// Straight from registers, so a new size applies the cycle after the write
	always_comb
	begin
		maxReadRequestBytes = readSizeBytes(cur.misc);
	end

endmodule
`default_nettype wire

// File: testbench/uhmpc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uhmpc_checker
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic cfgRead,
	input wire logic cfgWrite,
	input wire logic [7:0] cfgAddr,
	input wire logic [31:0] cfgWrData,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgRdData,
	input wire logic basicMode,
	input wire logic [9:0] maxReadRequestBytes,
	input wire logic prefetchEnable,
	input wire logic [6:0] prefetch_length_dwords,
	input wire logic [1:0] powerState,
	input wire logic pmeRequest,
	input wire logic hotResetPulse
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	wire logic rdA = clkEn && cfgRead;
	wire logic wrMisc = clkEn && cfgWrite && cfgAddr == 8'h68;
	wire logic wrPm = clkEn && cfgWrite && cfgAddr == 8'h84 && cfgByteEn[0];
	basic_mode_a: assert property (wrMisc && cfgByteEn[0] |=> basicMode == $past(cfgWrData[0]))
		else $error("basic mode wrong");
	read_size_a: assert property (wrMisc && cfgByteEn[0] |=>
		maxReadRequestBytes == ($past(cfgWrData[1]) ? 10'h040 : 10'h080))
		else $error("read size wrong");
	prefetch_on_a: assert property (wrMisc && cfgByteEn[0] |=> prefetchEnable == $past(cfgWrData[2]))
		else $error("prefetch enable wrong");
	prefetch_len_a: assert property (wrMisc && cfgByteEn[1] |=>
		prefetch_length_dwords == $past(cfgWrData[14:8]))
		else $error("prefetch length wrong");
	pm_fixed_a: assert property (rdA && cfgAddr == 8'h80 |=>
		cfgRdData[20:16] == 5'h03 && cfgRdData[7:0] == 8'h01)
		else $error("pm capability wrong");
	msi_id_a: assert property (rdA && cfgAddr == 8'h8C |=> cfgRdData[7:0] == 8'h05)
		else $error("msi id wrong");
	power_state_a: assert property (wrPm |=> powerState == $past(cfgWrData[1:0]))
		else $error("power state wrong");
	pmcsr_zero_a: assert property (rdA && cfgAddr == 8'h84 |=> cfgRdData[31:22] == 10'h000
		&& cfgRdData[14:13] == 2'h0 && cfgRdData[7:4] == 4'h0 && !cfgRdData[2])
		else $error("pm status zero fields wrong");
	hot_clear_a: assert property (hotResetPulse |=>
		!hotResetPulse && powerState == 2'h0 && !pmeRequest)
		else $error("hot reset wrong");
	cover property (hotResetPulse);
	cover property (pmeRequest);
	cover property (wrMisc);
endmodule
bind uhmpc_regs uhmpc_checker uhmpc_checker_i (.*);
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'h0, rst_b = 1'h0, clkEn = 1'h1, cfgRead = 1'h0, cfgWrite = 1'h0;
	logic loadValid = 1'h0, wakeEvent = 1'h0, cfgRdValid, basicMode, prefetchEnable;
	logic pmeRequest, hotResetPulse;
	logic [7:0] cfgAddr = '0, loadAddr = '0;
	logic [31:0] cfgWrData = '0, loadData = '0, cfgRdData, d;
	logic [3:0] cfgByteEn = '0;
	logic [9:0] maxReadRequestBytes;
	logic [6:0] prefetch_length_dwords;
	logic [1:0] powerState;
	logic [31:0] expQ[$], maskQ[$];
	int failures = 0, checks_done = 0, hotSeen = 0;
	integer seed = 32'hA62F107D;
	// Full/low-speed flavour so the wake status is live
	uhmpc_regs #(.HIGH_SPEED_FUNC(1'b0)) uhmpc_regs_i (.*);
	always #2 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Idle cycle after each request keeps strobes single-assigned
	task automatic cyc(input logic r, w, l, input logic [7:0] a, input logic [31:0] dt,
		input logic [3:0] be);
		{cfgRead, cfgWrite, loadValid} = {r, w, l};
		{cfgAddr, loadAddr, cfgWrData, loadData, cfgByteEn} = {a, a, dt, dt, be};
		@(posedge ref_clk);
		#1;
		{cfgRead, cfgWrite, loadValid} = '0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		expQ.push_back(e & m);
		maskQ.push_back(m);
		cyc(1'h1, 1'h0, 1'h0, a, '0, '0);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge ref_clk)
		if (cfgRdValid) chk(cfgRdData & maskQ.pop_front(), expQ.pop_front());
	always @(posedge ref_clk)
		if (hotResetPulse) hotSeen++;
	initial
	begin
		#20000;
		failures++;
		test_done();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		#1;
		rst_b = 1'h1;
		rd(8'h68, 32'h00009000, '1);
		rd(8'h80, 32'hFFC38C01, '1);
		rd(8'h84, 32'h00000008, '1);
		rd(8'h8C, 32'h00000005, 32'h000000FF);
		rd(8'h70, '0, '1);
		$display("test reset_values done");
		repeat (6)
		begin
			d = $random(seed);
			cyc(1'h0, 1'h1, 1'h0, 8'h68, d, 4'hF);
			chk(basicMode, d[0]);
			chk(maxReadRequestBytes, d[1] ? 10'h040 : 10'h080);
			chk(prefetchEnable, d[2]);
			chk(prefetch_length_dwords, d[14:8]);
			rd(8'h68, d & 32'h0000FF7F, '1);
		end
		cyc(1'h0, 1'h1, 1'h0, 8'h80, '1, 4'hF);
		rd(8'h80, 32'hFFC38C01, '1);
		$display("test misc done");
		for (int s = 0; s < 4; s++)
		begin
			cyc(1'h0, 1'h1, 1'h0, 8'h84, 32'h00001F00 | s, 4'h3);
			chk(powerState, s[1:0]);
			rd(8'h84, 32'h00001F08 | s, '1);
		end
		wakeEvent = 1'h1;
		@(posedge ref_clk);
		#1;
		wakeEvent = 1'h0;
		@(posedge ref_clk);
		#1;
		chk(pmeRequest, 1'h1);
		cyc(1'h0, 1'h1, 1'h0, 8'h84, 32'h00001F03, 4'h3);
		rd(8'h84, 32'h00009F0B, '1);
		cyc(1'h0, 1'h1, 1'h0, 8'h84, 32'h00009F03, 4'h3);
		chk(pmeRequest, 1'h0);
		cyc(1'h0, 1'h1, 1'h0, 8'h84, '0, 4'h1);
		chk(hotSeen, 0);
		$display("test power done");
		cyc(1'h0, 1'h0, 1'h1, 8'h80, 32'h00004000, 4'h0);
		rd(8'h80, 32'h00034001, '1);
		cyc(1'h0, 1'h0, 1'h1, 8'h84, '0, 4'h0);
		rd(8'h84, 32'h00001F00, '1);
		cyc(1'h0, 1'h1, 1'h0, 8'h84, 32'h00000003, 4'h1);
		cyc(1'h0, 1'h1, 1'h0, 8'h84, '0, 4'h1);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(hotSeen, 1);
		rd(8'h84, '0, '1);
		repeat (4) @(posedge ref_clk);
		chk(expQ.size(), 0);
		$display("test load_hot_reset done");
		test_done();
	end
endmodule
`default_nettype wire
